//--- sas_afe_model.sv
// Behavioural analog front end: one level per input, comparator on taps
`timescale 1ns/1ps
`default_nettype none
module sas_afe_model (
    input  wire logic                 clock,
    input  wire sas_pkg::sas_afe_type afe,
    input  wire logic [9:0]           vin [6],
    output logic                      cmp_high
);
    logic junk_reg = 1'b0;
    always_ff @(posedge clock) begin
        junk_reg <= ~junk_reg;
    end
    // Decision only meaningful while held
    assign cmp_high = afe.hold ? (vin[afe.channel] >= afe.tap_code) : junk_reg;
endmodule : sas_afe_model
`default_nettype wire

//--- sas_approx.sv
// Successive approximation register, one bit per step
`timescale 1ns/1ps
`default_nettype none
module sas_approx (
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic       wide,
    input  wire logic       clear,
    input  wire logic       step,
    input  wire logic       cmp_high,
    output logic [9:0]      code
);
    logic [9:0] code_reg;
    logic [9:0] bit_reg;

    assign code = code_reg;

    // ==========================================
    // Trial bit walks from MSB to LSB
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            code_reg <= 10'h000;
            bit_reg  <= 10'h000;
        end else if (clear) begin
            code_reg <= wide ? 10'h200 : 10'h080;
            bit_reg  <= wide ? 10'h200 : 10'h080;
        end else if (step && bit_reg != 10'h000) begin
            code_reg <= (cmp_high ? code_reg : (code_reg & ~bit_reg)) | (bit_reg >> 1);
            bit_reg  <= bit_reg >> 1;
        end
    end

endmodule : sas_approx
`default_nettype wire

//--- sas_checker.sv
// Assertion checker for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module sas_checker (
    input wire logic                 clock,
    input wire logic                 nrst,
    input wire sas_pkg::sas_bus_type bus,
    input wire logic [15:0]          rdata,
    input wire logic                 rvalid,
    input wire logic                 standby,
    input wire sas_pkg::sas_afe_type afe,
    input wire logic                 conv_end_irq,
    input wire logic                 conv_end_flag
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    wire logic cfg_wr = bus.wr && (bus.addr == sas_pkg::SAS_MODE_ADDR
        || bus.addr == sas_pkg::SAS_CHAN_ADDR);
    // ==========================================
    // Properties
    a_irq_one_cycle: assert property (conv_end_irq |=> !conv_end_irq)
        else $error("completion request longer than one cycle");
    a_rvalid_per_read: assert property (rvalid == $past(bus.rd))
        else $error("read answer missing or spurious");
    a_result_pad_zero: assert property (bus.rd && bus.word
        && bus.addr == sas_pkg::SAS_RESULT_ADDR |=> rdata[5:0] == 6'h00)
        else $error("low result bits not zero");
    a_standby_halts: assert property (standby [*2] |-> !afe.active)
        else $error("converting in standby");
    a_hold_at_end: assert property (conv_end_irq |-> $past(afe.hold))
        else $error("input not held up to completion");
    a_cfg_write_wins: assert property (cfg_wr |=> !conv_end_irq)
        else $error("completion request despite register write");
    a_flag_from_irq: assert property ($rose(conv_end_flag)
        |-> conv_end_irq || $past(conv_end_irq))
        else $error("flag set without completion");
    a_start_by_write: assert property ($rose(afe.active) |-> $past(cfg_wr)
        || $past(cfg_wr, 2) || $past(standby, 2) || $past(standby, 3))
        else $error("conversion started without software write");
endmodule : sas_checker
bind sas_sequencer sas_checker i_chk (.clock(clock), .nrst(nrst), .bus(bus),
    .rdata(rdata), .rvalid(rvalid), .standby(standby), .afe(afe),
    .conv_end_irq(conv_end_irq), .conv_end_flag(conv_end_flag));
`default_nettype wire

//--- sas_pkg.sv
// Package of constants and types for the converter sequencer
package sas_pkg;

    // ==========================================
    // Register addresses
    localparam logic [15:0] SAS_MODE_ADDR    = 16'hFF80;
    localparam logic [15:0] SAS_CHAN_ADDR    = 16'hFF84;
    localparam logic [15:0] SAS_RESULT_ADDR  = 16'hFF14;
    localparam logic [15:0] SAS_RESULT_HADDR = 16'hFF15;

    // ==========================================
    // Field positions and reset values
    localparam int          SAS_ENABLE_BIT   = 7;
    localparam int          SAS_TIME_LSB     = 3;
    localparam logic [7:0]  SAS_MODE_MASK    = 8'hB8;
    localparam logic [7:0]  SAS_CHAN_MASK    = 8'h07;
    localparam logic [7:0]  SAS_MODE_RESET   = 8'h00;
    localparam logic [7:0]  SAS_CHAN_RESET   = 8'h00;
    localparam logic [15:0] SAS_RESULT_RESET = 16'h0000;
    localparam int          SAS_WIDE_PAD     = 6;
    localparam logic [2:0]  SAS_LAST_CHAN    = 3'h5;

    // ==========================================
    // Timing: conversion lengths in main-clock cycles, slot count and sample slots
    localparam logic [7:0]  SAS_CONV_144     = 8'h90;
    localparam logic [7:0]  SAS_CONV_120     = 8'h78;
    localparam logic [7:0]  SAS_CONV_96      = 8'h60;
    localparam logic [7:0]  SAS_CONV_72      = 8'h48;
    localparam logic [3:0]  SAS_SLOTS        = 4'hC;
    localparam logic [3:0]  SAS_SAMPLE_WIDE  = 4'h2;
    localparam logic [3:0]  SAS_SAMPLE_NARROW = 4'h4;

    typedef enum logic [2:0] {
        SAS_T144 = 3'h0,
        SAS_T120 = 3'h1,
        SAS_T96  = 3'h2,
        SAS_T72  = 3'h4
    } sas_time_type;

    // CPU access, one request per cycle
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        word;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } sas_bus_type;

    // Drive towards the analog front end
    typedef struct packed {
        logic       active;
        logic [2:0] channel;
        logic       hold;
        logic [9:0] tap_code;
    } sas_afe_type;

endpackage : sas_pkg

//--- sas_sequencer.sv
// Control, timing and result logic of the six-input converter
`timescale 1ns/1ps
`default_nettype none
module sas_sequencer #(
    parameter bit WIDE  = 1'b1,
    parameter bit FLASH = 1'b0
) (
    input  wire logic                 clock,
    input  wire logic                 nrst,
    input  wire sas_pkg::sas_bus_type bus,
    output logic [15:0]               rdata,
    output logic                      rvalid,
    input  wire logic                 standby,
    input  wire logic                 cmp_high,
    output sas_pkg::sas_afe_type      afe,
    output logic                      conv_end_irq,
    input  wire logic                 flag_clear,
    output logic                      conv_end_flag
);
    typedef enum logic { SAS_IDLE, SAS_RUN } sas_state_type;

    sas_state_type state_reg;
    logic [7:0]    converter_mode_reg;
    logic [7:0]    channel_select_reg;
    logic [15:0]   conversion_result_reg;
    logic [15:0]   pending_reg;
    logic          pending_valid_reg;
    logic [7:0]    slot_cnt_reg;
    logic [3:0]    slot_idx_reg;
    logic [15:0]   rdata_reg;
    logic          rvalid_reg;
    logic          irq_reg;
    logic          flag_reg;
    logic [9:0]    code;
    logic          ctrl_write;
    logic          res_read;
    logic          slot_end;
    logic          conv_done;
    logic          run_ok;
    logic [7:0]    slot_len;
    logic [15:0]   new_result;

    // ==========================================
    // Conversion length per time code
    function automatic logic [7:0] conv_cycles(input logic [2:0] sel);
        unique case (sel)
            sas_pkg::SAS_T120: conv_cycles = sas_pkg::SAS_CONV_120;
            sas_pkg::SAS_T96:  conv_cycles = sas_pkg::SAS_CONV_96;
            sas_pkg::SAS_T72:  conv_cycles = sas_pkg::SAS_CONV_72;
            default:  conv_cycles = sas_pkg::SAS_CONV_144;
        endcase
    endfunction : conv_cycles

    // ==========================================
    // Decode
    assign ctrl_write = bus.wr && (bus.addr == sas_pkg::SAS_MODE_ADDR ||
                                   bus.addr == sas_pkg::SAS_CHAN_ADDR);
    assign res_read   = bus.rd && (bus.addr == sas_pkg::SAS_RESULT_ADDR ||
                                   bus.addr == sas_pkg::SAS_RESULT_HADDR);
    assign run_ok     = converter_mode_reg[sas_pkg::SAS_ENABLE_BIT] && !standby;
    assign slot_len   = conv_cycles(converter_mode_reg[sas_pkg::SAS_TIME_LSB +: 3])
                        / {4'h0, sas_pkg::SAS_SLOTS};
    assign slot_end   = (state_reg == SAS_RUN) && (slot_cnt_reg == slot_len - 8'd1);
    assign conv_done  = slot_end && (slot_idx_reg == sas_pkg::SAS_SLOTS - 4'h1);
    // Bit 0 straight from the comparator, register settles one edge late
    assign new_result = WIDE ? {code[9:1], cmp_high, {sas_pkg::SAS_WIDE_PAD{1'b0}}}
                             : {8'h00, code[7:1], cmp_high};

    // ==========================================
    // Control registers
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            converter_mode_reg <= sas_pkg::SAS_MODE_RESET;
            channel_select_reg <= sas_pkg::SAS_CHAN_RESET;
        end else if (bus.wr) begin
            if (bus.addr == sas_pkg::SAS_MODE_ADDR) begin
                converter_mode_reg <= bus.wdata & sas_pkg::SAS_MODE_MASK;
            end
            if (bus.addr == sas_pkg::SAS_CHAN_ADDR) begin
                channel_select_reg <= bus.wdata & sas_pkg::SAS_CHAN_MASK;
            end
        end
    end

    // ==========================================
    // Sequencing state and slot timing
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_reg    <= SAS_IDLE;
            slot_cnt_reg <= 8'h00;
            slot_idx_reg <= 4'h0;
        end else if (ctrl_write || !run_ok) begin
            state_reg    <= SAS_IDLE;
            slot_cnt_reg <= 8'h00;
            slot_idx_reg <= 4'h0;
        end else begin
            unique case (state_reg)
                SAS_IDLE: begin
                    state_reg <= SAS_RUN;
                end
                SAS_RUN: begin
                    if (slot_end) begin
                        slot_cnt_reg <= 8'h00;
                        slot_idx_reg <= conv_done ? 4'h0 : slot_idx_reg + 4'h1;
                    end else begin
                        slot_cnt_reg <= slot_cnt_reg + 8'h01;
                    end
                end
            endcase
        end
    end

    sas_approx u_approx (
        .clock    (clock),
        .nrst     (nrst),
        .wide     (WIDE),
        .clear    (state_reg == SAS_RUN && slot_cnt_reg == 8'h00 &&
                   slot_idx_reg == 4'h0),
        .step     (slot_end && !afe.hold ? 1'b0 : slot_end),
        .cmp_high (cmp_high),
        .code     (code)
    );

    // ==========================================
    // Front end drive
    always_comb begin
        afe.active   = state_reg == SAS_RUN;
        afe.channel  = channel_select_reg[2:0];
        afe.hold     = afe.active && slot_idx_reg >= (WIDE ? sas_pkg::SAS_SAMPLE_WIDE
                                                           : sas_pkg::SAS_SAMPLE_NARROW);
        afe.tap_code = code;
    end

    // ==========================================
    // Result store with read and write conflicts
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            conversion_result_reg <= sas_pkg::SAS_RESULT_RESET;
            pending_reg           <= 16'h0000;
            pending_valid_reg     <= 1'b0;
            irq_reg               <= 1'b0;
        end else begin
            irq_reg <= conv_done && !ctrl_write;
            if (conv_done && !ctrl_write) begin
                if (res_read) begin
                    pending_reg       <= new_result;
                    pending_valid_reg <= 1'b1;
                end else begin
                    conversion_result_reg <= new_result;
                    pending_valid_reg     <= 1'b0;
                end
            end else if (pending_valid_reg && !res_read) begin
                conversion_result_reg <= pending_reg;
                pending_valid_reg     <= 1'b0;
            end
        end
    end

    // ==========================================
    // Completion flag, set wins over clear
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            flag_reg <= 1'b0;
        end else if (irq_reg) begin
            flag_reg <= 1'b1;
        end else if (flag_clear) begin
            flag_reg <= 1'b0;
        end
    end

    // ==========================================
    // Read data
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata_reg  <= 16'h0000;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= bus.rd;
            rdata_reg  <= 16'h0000;
            if (bus.rd) begin
                unique case (bus.addr)
                    sas_pkg::SAS_MODE_ADDR:    rdata_reg <= {8'h00, converter_mode_reg};
                    sas_pkg::SAS_CHAN_ADDR:    rdata_reg <= {8'h00, channel_select_reg};
                    sas_pkg::SAS_RESULT_ADDR: begin
                        if (bus.word) begin
                            rdata_reg <= conversion_result_reg;
                        end else if (FLASH) begin
                            rdata_reg <= {8'h00, conversion_result_reg[7:0]};
                        end
                    end
                    sas_pkg::SAS_RESULT_HADDR: begin
                        if (!bus.word && FLASH) begin
                            rdata_reg <= {8'h00, conversion_result_reg[15:8]};
                        end
                    end
                    default: rdata_reg <= 16'h0000;
                endcase
            end
        end
    end

    assign rdata         = rdata_reg;
    assign rvalid        = rvalid_reg;
    assign conv_end_irq  = irq_reg;
    assign conv_end_flag = flag_reg;

endmodule : sas_sequencer
`default_nettype wire

//--- sas_sequencer_tb.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module sas_sequencer_tb;
    logic                 clock = 1'b0;
    logic                 nrst = 1'b0;
    logic                 standby = 1'b0;
    logic                 flag_clear = 1'b0;
    sas_pkg::sas_bus_type bus = '0;
    sas_pkg::sas_afe_type afe;
    logic [15:0]          rdata;
    logic                 rvalid, cmp_high, conv_end_irq, conv_end_flag;
    logic [9:0]           vin [6];
    logic [15:0]          exp_q [$];
    logic [31:0]          seed = 32'h00000038;
    logic [2:0]           tcode [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
    int                   tlen [4] = '{144, 120, 96, 72};
    int                   n_fail = 0;
    int                   cmp_count = 0;
    int                   per;
    sas_sequencer #(.WIDE(1'b1), .FLASH(1'b1)) i_dut (.clock(clock), .nrst(nrst),
        .bus(bus), .rdata(rdata),
        .rvalid(rvalid), .standby(standby), .cmp_high(cmp_high), .afe(afe),
        .conv_end_irq(conv_end_irq), .flag_clear(flag_clear), .conv_end_flag(conv_end_flag));
    sas_afe_model i_afe (.clock(clock), .afe(afe), .vin(vin), .cmp_high(cmp_high));
    initial begin
        forever #10 clock = ~clock;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        cmp_count++;
        if (got !== want) begin
            n_fail++;
            $display("ERROR t=%0t got=%h want=%h", $time, got, want);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        bus <= '{rd: 1'b0, wr: 1'b1, word: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        bus <= '0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic w, input logic [15:0] e);
        exp_q.push_back(e);
        @(posedge clock);
        bus <= '{rd: 1'b1, wr: 1'b0, word: w, addr: a, wdata: 8'h00};
        @(posedge clock);
        bus <= '0;
    endtask : rd
    // Cycles up to the next completion request, 400 means none
    task automatic wait_irq(output int n);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (conv_end_irq !== 1'b1 && n < 400);
    endtask : wait_irq
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run
    // ==========================================
    // Read monitor: oldest note against each answer
    always @(posedge clock) begin
        if (rvalid === 1'b1) begin
            chk(rdata, exp_q.pop_front());
        end
    end
    initial begin
        #400000;
        n_fail++;
        complete_run();
    end
    // ==========================================
    // Scenarios
    initial begin
        for (int i = 0; i < 6; i++) begin
            vin[i] = 10'(xs());
        end
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        rd(sas_pkg::SAS_RESULT_ADDR, 1'b1, 16'h0000);
        rd(sas_pkg::SAS_MODE_ADDR, 1'b0, 16'h0000);
        wr(sas_pkg::SAS_RESULT_ADDR, 8'hFF);
        rd(sas_pkg::SAS_RESULT_ADDR, 1'b1, 16'h0000);
        rd(16'hFFF0, 1'b1, 16'h0000);
        wait_irq(per);
        chk(per, 400);
        for (int k = 0; k < 6; k++) begin
            wr(sas_pkg::SAS_CHAN_ADDR, 8'(k));
            flag_clear <= 1'b1;
            wr(sas_pkg::SAS_MODE_ADDR, {2'b10, tcode[k % 4], 3'b000});
            flag_clear <= 1'b0;
            wait_irq(per);
            chk(afe.channel, k);
            wait_irq(per);
            chk(per, tlen[k % 4]);
            rd(sas_pkg::SAS_RESULT_ADDR, 1'b1, {vin[k], 6'h00});
            rd(sas_pkg::SAS_MODE_ADDR, 1'b0, {8'h00, 2'b10, tcode[k % 4], 3'b000});
        end
        rd(sas_pkg::SAS_RESULT_ADDR, 1'b0, {8'h00, vin[5][1:0], 6'h00});
        rd(sas_pkg::SAS_RESULT_HADDR, 1'b0, {8'h00, vin[5][9:2]});
        rd(sas_pkg::SAS_RESULT_HADDR, 1'b1, 16'h0000);
        wr(sas_pkg::SAS_MODE_ADDR, 8'h80);
        #1;
        chk(conv_end_flag, 1);
        @(posedge clock);
        flag_clear <= 1'b1;
        @(posedge clock);
        flag_clear <= 1'b0;
        #1;
        chk(conv_end_flag, 0);
        repeat (100) @(posedge clock);
        wr(sas_pkg::SAS_CHAN_ADDR, 8'h02);
        wait_irq(per);
        chk(32'(per > 140), 1);
        standby <= 1'b1;
        repeat (3) @(posedge clock);
        wait_irq(per);
        chk(per, 400);
        standby <= 1'b0;
        wait_irq(per);
        chk(32'(per < 400), 1);
        // Read lands on the next completion edge: old value, then new
        vin[2] <= ~vin[2];
        repeat (tlen[0] - 3) @(posedge clock);
        rd(sas_pkg::SAS_RESULT_ADDR, 1'b1, {~vin[2], 6'h00});
        rd(sas_pkg::SAS_RESULT_ADDR, 1'b1, {vin[2], 6'h00});
        wr(sas_pkg::SAS_MODE_ADDR, 8'h00);
        wait_irq(per);
        chk(per, 400);
        complete_run();
    end
endmodule : sas_sequencer_tb
`default_nettype wire
